// ---- pms_pkg.sv ----
// package for the push motion sequencer: register map, fields, limits, timing
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pms_pkg;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_START_SPEED = 8'h08;
  localparam logic [7:0] ADDR_MOVE_SPEED = 8'h0C;
  localparam logic [7:0] ADDR_POS_TARGET = 8'h10;
  localparam logic [7:0] ADDR_ACC_TIME = 8'h14;
  localparam logic [7:0] ADDR_DEC_TIME = 8'h18;
  localparam logic [7:0] ADDR_PUSH_RATIO = 8'h1C;
  localparam logic [7:0] ADDR_PUSH_SPEED = 8'h20;
  localparam logic [7:0] ADDR_PUSH_TARGET = 8'h24;
  localparam logic [7:0] ADDR_PUSH_MODE = 8'h28;
  localparam logic [7:0] ADDR_POSITION = 8'h2C;
  localparam logic [7:0] ADDR_TABLE_BASE = 8'h40;

  // ************************************************
  // control and status fields
  // ************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PUSH_BIT = 1;
  localparam int ST_INPOS_BIT = 2;
  localparam int ST_END_BIT = 3;
  localparam int ST_DETECT_BIT = 4;
  localparam int ST_ALARM_MASK_BIT = 5;
  localparam int ST_REJECT_BIT = 6;

  // ************************************************
  // setting limits
  // ************************************************
  localparam logic [31:0] START_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] START_SPEED_MAX = 32'd35000;
  localparam logic [31:0] MOVE_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] MOVE_SPEED_MAX = 32'd500000;
  localparam logic [31:0] TIME_MIN_MS = 32'h0000_0001;
  localparam logic [31:0] TIME_MAX_MS = 32'd9999;
  localparam logic [31:0] RATIO_MIN = 32'd20;
  localparam logic [31:0] RATIO_MAX = 32'd80;
  localparam logic [31:0] PUSH_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] PUSH_SPEED_MAX = 32'd66000;
  localparam logic [31:0] PUSH_RPM_MAX = 32'd400;
  localparam logic [31:0] ENCODER_PPR = 32'd10000;
  localparam logic [31:0] PUSH_SPEED_RPM_CAP = (PUSH_RPM_MAX * ENCODER_PPR) / 32'd60;
  localparam logic [31:0] PUSH_MODE_MAX = 32'd10000;
  localparam logic signed [31:0] POS_LIMIT = 32'sd134217727;
  localparam logic [31:0] RETREAT_SPEED = 32'd5000;

  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [31:0] RST_START_SPEED = 32'h0000_0001;
  localparam logic [31:0] RST_MOVE_SPEED = 32'h0000_0001;
  localparam logic [31:0] RST_TIME = 32'h0000_0001;
  localparam logic [31:0] RST_RATIO = 32'd20;
  localparam logic [31:0] RST_PUSH_SPEED = 32'h0000_0001;

  // one motion setting set, shared by host registers and table entries
  typedef struct packed {
    logic [31:0] start_speed;
    logic [31:0] move_speed;
    logic signed [31:0] pos_target;
    logic [31:0] acc_ms;
    logic [31:0] dec_ms;
    logic [31:0] ratio;
    logic [31:0] push_speed;
    logic signed [31:0] push_target;
    logic [31:0] push_mode;
  } pms_cfg_t;

endpackage : pms_pkg

// ---- pms_rate_gen.sv ----
// pulse-rate generator: emits step ticks at a given pulses-per-second rate
// assumes the 100 MHz system clock and rate below the clock rate
`timescale 1ns/1ps
`default_nettype none
module pms_rate_gen
  import pms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [31:0] rate_i,
  output logic tick_o
);

  logic [31:0] acc;
  logic [32:0] sum;

  assign sum = {1'b0, acc} + {1'b0, rate_i};

  // phase accumulator, one tick per clk_hz of accumulated rate
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      acc <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (sum >= 33'(CLK_HZ)) begin
      acc <= 32'(sum - 33'(CLK_HZ));
      tick_o <= 1'b1;
    end else begin
      acc <= sum[31:0];
      tick_o <= 1'b0;
    end
  end

endmodule : pms_rate_gen
`default_nettype wire

// ---- pms_core.sv ----
// push motion sequencer top: wishbone registers, move profile, push phase
// assumes load_i is a relative load in percent of stall torque, sync to clk_i
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - push torque limit 20..80 percent, torque limited to it while pushing
// - push speed 1..66000 pps and at most 400 rpm
// - push mode zero is stop mode, 1..10000 is non-stop mode
// - non-stop stop command backs off push mode value pulses
// - halt when position reaches push target even without detection
// - position start speed accepted in 1..35000 pps
// - position moving speed accepted in 1..500000 pps
// - acceleration and deceleration times accepted in 1..9999 ms
// - targets are absolute, magnitude at most 134217727 pulses
// - start from host command or table start input with table entries
// - no detection: in-position and end stay off until stop command
// - in non-stop mode, work lost after detection clears in-position, end stays on
// - push phase ends at the push end position
// - tracking and overload alarms suppressed while pushing
// - pps values refer to 10000 pulses per revolution
// - decelerate from position speed to push speed before pushing
// - stop mode holds torque and flags done; stop releases to position
// - backward retreat runs at 5000 pps
module pms_core
  import pms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic table_move_start_input_i,
  input wire logic [2:0] table_index_i,
  input wire logic [7:0] load_i,
  output logic step_o,
  output logic dir_o,
  output logic [7:0] torque_limit_o,
  output logic inposition_o,
  output logic end_o,
  output logic alarm_suppress_o
);

  // ************************************************
  // state and storage
  // ************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MOVE = 3'b001,
    ST_DECEL = 3'b011,
    ST_PUSH = 3'b010,
    ST_HOLD = 3'b110,
    ST_RETREAT = 3'b111,
    ST_DONE = 3'b101
  } pms_state_t;

  pms_state_t state;
  pms_cfg_t cfg;
  pms_cfg_t act;
  pms_cfg_t table_mem [8];
  logic signed [31:0] position;
  logic [31:0] speed;
  logic [31:0] next_speed;
  logic [31:0] ramp_cnt;
  logic [31:0] retreat_left;
  logic detected;
  logic reject;
  logic start_cmd;
  logic stop_cmd;
  logic table_start_d;
  logic step_tick;
  logic run;
  logic [31:0] rd_data;
  logic [31:0] wdata;
  logic wr;
  logic cfg_ok;
  logic [31:0] rate_sel;
  logic [31:0] push_speed_eff;
  logic [5:0] tbl_rel;

  // write lands at the edge where the master sees ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  // word offset inside the position table
  assign tbl_rel = wb_adr_i[7:2] - ADDR_TABLE_BASE[7:2];
  assign wdata = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ************************************************
  // wishbone slave
  // ************************************************
  // ack one cycle after request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_STATUS: begin
        rd_data[ST_BUSY_BIT] = (state != ST_IDLE) && (state != ST_DONE);
        rd_data[ST_PUSH_BIT] = (state == ST_PUSH) || (state == ST_HOLD);
        rd_data[ST_INPOS_BIT] = inposition_o;
        rd_data[ST_END_BIT] = end_o;
        rd_data[ST_DETECT_BIT] = detected;
        rd_data[ST_ALARM_MASK_BIT] = alarm_suppress_o;
        rd_data[ST_REJECT_BIT] = reject;
      end
      ADDR_START_SPEED: rd_data = cfg.start_speed;
      ADDR_MOVE_SPEED: rd_data = cfg.move_speed;
      ADDR_POS_TARGET: rd_data = cfg.pos_target;
      ADDR_ACC_TIME: rd_data = cfg.acc_ms;
      ADDR_DEC_TIME: rd_data = cfg.dec_ms;
      ADDR_PUSH_RATIO: rd_data = cfg.ratio;
      ADDR_PUSH_SPEED: rd_data = cfg.push_speed;
      ADDR_PUSH_TARGET: rd_data = cfg.push_target;
      ADDR_PUSH_MODE: rd_data = cfg.push_mode;
      ADDR_POSITION: rd_data = position;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // setting registers, stored as written and checked at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.start_speed <= RST_START_SPEED;
      cfg.move_speed <= RST_MOVE_SPEED;
      cfg.pos_target <= 32'h0000_0000;
      cfg.acc_ms <= RST_TIME;
      cfg.dec_ms <= RST_TIME;
      cfg.ratio <= RST_RATIO;
      cfg.push_speed <= RST_PUSH_SPEED;
      cfg.push_target <= 32'h0000_0000;
      cfg.push_mode <= 32'h0000_0000;
    end else if (wr) begin
      unique case (wb_adr_i)
        ADDR_START_SPEED: cfg.start_speed <= wdata;
        ADDR_MOVE_SPEED: cfg.move_speed <= wdata;
        ADDR_POS_TARGET: cfg.pos_target <= wdata;
        ADDR_ACC_TIME: cfg.acc_ms <= wdata;
        ADDR_DEC_TIME: cfg.dec_ms <= wdata;
        ADDR_PUSH_RATIO: cfg.ratio <= wdata;
        ADDR_PUSH_SPEED: cfg.push_speed <= wdata;
        ADDR_PUSH_TARGET: cfg.push_target <= wdata;
        ADDR_PUSH_MODE: cfg.push_mode <= wdata;
        default: ;
      endcase
    end
  end

  // position table: nine words per entry from the table base
  always_ff @(posedge clk_i) begin
    if (wr && wb_adr_i >= ADDR_TABLE_BASE) begin
      table_mem[3'(tbl_rel / 6'd9)][(8 - int'(tbl_rel % 6'd9)) * 32 +: 32] <= wdata;
    end
  end

  // command pulses from control writes and the table start edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_cmd <= 1'b0;
      stop_cmd <= 1'b0;
      table_start_d <= 1'b0;
    end else begin
      start_cmd <= wr && (wb_adr_i == ADDR_CTRL) && wdata[CTRL_START_BIT];
      stop_cmd <= wr && (wb_adr_i == ADDR_CTRL) && wdata[CTRL_STOP_BIT];
      table_start_d <= table_move_start_input_i;
    end
  end

  // ************************************************
  // setting checks
  // ************************************************
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic pos_ok(input logic signed [31:0] p);
    pos_ok = (p <= POS_LIMIT) && (p >= -POS_LIMIT);
  endfunction : pos_ok

  pms_cfg_t src;
  logic table_go;
  assign table_go = table_move_start_input_i && !table_start_d;
  assign src = table_go ? table_mem[table_index_i] : cfg;

  assign cfg_ok = in_range(src.start_speed, START_SPEED_MIN, START_SPEED_MAX)
               && in_range(src.move_speed, MOVE_SPEED_MIN, MOVE_SPEED_MAX)
               && in_range(src.acc_ms, TIME_MIN_MS, TIME_MAX_MS)
               && in_range(src.dec_ms, TIME_MIN_MS, TIME_MAX_MS)
               && in_range(src.ratio, RATIO_MIN, RATIO_MAX)
               && in_range(src.push_speed, PUSH_SPEED_MIN, PUSH_SPEED_MAX)
               && (src.push_mode <= PUSH_MODE_MAX)
               && pos_ok(src.pos_target) && pos_ok(src.push_target);

  // cap push speed at 400 rpm of a 10000 ppr encoder
  assign push_speed_eff = (act.push_speed > PUSH_SPEED_RPM_CAP) ? PUSH_SPEED_RPM_CAP : act.push_speed;

  // ************************************************
  // motion engine
  // ************************************************
  // fixed retreat rate, otherwise the profile speed
  assign rate_sel = (state == ST_RETREAT) ? RETREAT_SPEED : speed;
  assign run = (state == ST_MOVE) || (state == ST_DECEL) || (state == ST_PUSH) || (state == ST_RETREAT);

  pms_rate_gen u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .rate_i(rate_sel),
    .tick_o(step_tick)
  );

  // linear ramp: one speed step of (span / time) + 1 every millisecond
  always_comb begin
    next_speed = speed;
    if (ramp_cnt == 32'(MS_CYCLES - 1)) begin
      if (state == ST_MOVE && speed < act.move_speed) begin
        next_speed = speed + ((act.move_speed - act.start_speed) / act.acc_ms) + 32'h0000_0001;
        if (next_speed > act.move_speed) next_speed = act.move_speed;
      end else if (state == ST_DECEL) begin
        next_speed = speed - ((act.move_speed - push_speed_eff) / act.dec_ms) - 32'h0000_0001;
        if (speed <= push_speed_eff + ((act.move_speed - push_speed_eff) / act.dec_ms) + 32'h0000_0001) begin
          next_speed = push_speed_eff;
        end
      end
    end
  end

  // main sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      act <= '0;
      speed <= 32'h0000_0000;
      ramp_cnt <= 32'h0000_0000;
      retreat_left <= 32'h0000_0000;
      detected <= 1'b0;
      reject <= 1'b0;
      inposition_o <= 1'b0;
      end_o <= 1'b0;
    end else begin
      ramp_cnt <= (ramp_cnt == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ramp_cnt + 32'h0000_0001;
      speed <= next_speed;
      unique case (state)
        ST_IDLE, ST_DONE: begin
          if (start_cmd || table_go) begin
            reject <= !cfg_ok;
            if (cfg_ok) begin
              act <= src;
              speed <= src.start_speed;
              detected <= 1'b0;
              inposition_o <= 1'b0;
              end_o <= 1'b0;
              state <= ST_MOVE;
            end
          end
        end
        ST_MOVE: begin
          if (position == act.pos_target) begin
            state <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (speed == push_speed_eff) begin
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (load_i >= act.ratio[7:0]) begin
            detected <= 1'b1;
            inposition_o <= 1'b1;
            end_o <= 1'b1;
            if (act.push_mode == 32'h0000_0000) state <= ST_HOLD;
          end else if (detected) begin
            inposition_o <= 1'b0;
          end
          if (position >= act.push_target) begin
            state <= ST_HOLD;
          end
          // stop command flags done, retreats in non-stop mode
          if (stop_cmd) begin
            inposition_o <= 1'b1;
            end_o <= 1'b1;
            retreat_left <= act.push_mode;
            state <= (act.push_mode == 32'h0000_0000) ? ST_DONE : ST_RETREAT;
          end
        end
        ST_HOLD: begin
          // stop releases back to position mode
          if (stop_cmd) begin
            inposition_o <= 1'b1;
            end_o <= 1'b1;
            retreat_left <= act.push_mode;
            state <= (act.push_mode == 32'h0000_0000) ? ST_DONE : ST_RETREAT;
          end
        end
        ST_RETREAT: begin
          if (retreat_left == 32'h0000_0000) begin
            state <= ST_DONE;
          end else if (step_tick) begin
            retreat_left <= retreat_left - 32'h0000_0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // absolute position counter and step outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position <= 32'sh0000_0000;
      step_o <= 1'b0;
      dir_o <= 1'b0;
    end else begin
      step_o <= step_tick && !(state == ST_MOVE && position == act.pos_target);
      dir_o <= (state == ST_RETREAT) ? 1'b0 : (state == ST_MOVE) ? (act.pos_target >= position) : 1'b1;
      if (step_tick && state == ST_RETREAT && retreat_left != 32'h0000_0000) begin
        position <= position - 32'sh0000_0001;
      end else if (step_tick && state == ST_MOVE && position != act.pos_target) begin
        position <= (act.pos_target > position) ? position + 32'sh0000_0001 : position - 32'sh0000_0001;
      end else if (step_tick && (state == ST_DECEL || state == ST_PUSH)) begin
        position <= position + 32'sh0000_0001;
      end
    end
  end

  // torque limit and alarm suppression
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      torque_limit_o <= 8'h64;
      alarm_suppress_o <= 1'b0;
    end else begin
      // torque limited while pushing or holding
      torque_limit_o <= (state == ST_PUSH || state == ST_HOLD) ? act.ratio[7:0] : 8'h64;
      alarm_suppress_o <= (state == ST_PUSH);
    end
  end

endmodule : pms_core
`default_nettype wire

// ---- pms_core_chk.sv ----
// checker for the push motion sequencer, watching the core ports only
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module pms_core_chk
  import pms_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic step_o,
  input wire logic dir_o,
  input wire logic [7:0] torque_limit_o,
  input wire logic inposition_o,
  input wire logic end_o,
  input wire logic alarm_suppress_o
);
  // ****************
  // step spacing helper
  // ****************
  logic [15:0] gap;
  logic prev_sup;
  logic prev_dir;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the last step, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 16'h0000;
    end else if (step_o) begin
      gap <= 16'h0001;
    end else if (gap != 16'hFFFF) begin
      gap <= gap + 16'h0001;
    end
  end
  // phase and direction of the last step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_sup <= 1'b0;
      prev_dir <= 1'b1;
    end else if (step_o) begin
      prev_sup <= alarm_suppress_o;
      prev_dir <= dir_o;
    end
  end
  // ****************
  // properties
  // ****************
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_push_step;
    step_o && alarm_suppress_o && prev_sup;
  endsequence
  sequence s_back_step;
    step_o && !dir_o && !prev_dir;
  endsequence
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_when_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_torque_range: assert property (torque_limit_o == 8'h64 || (torque_limit_o >= 8'h14 && torque_limit_o <= 8'h50))
    else $error("torque limit outside push range");
  a_push_torque: assert property (alarm_suppress_o && $past(alarm_suppress_o) |-> torque_limit_o != 8'h64)
    else $error("alarm suppressed without push torque");
  a_inpos_end: assert property (inposition_o |-> end_o)
    else $error("in-position without end");
  a_step_single: assert property (step_o |=> !step_o [*8])
    else $error("step pulse too close");
  a_push_rate: assert property (s_push_step |-> gap >= 16'h05EB)
    else $error("push steps faster than allowed");
  a_retreat_rate: assert property (s_back_step |-> gap >= 16'h4E1F && gap <= 16'h4E21)
    else $error("retreat step rate wrong");
endmodule : pms_core_chk
bind pms_core pms_core_chk i_pms_core_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .step_o(step_o), .dir_o(dir_o),
  .torque_limit_o(torque_limit_o), .inposition_o(inposition_o), .end_o(end_o),
  .alarm_suppress_o(alarm_suppress_o));
`default_nettype wire

// ---- pms_load_model.sv ----
// mechanical load model: shaft position from steps, load rises at a work piece
// assumes step_i is a one-cycle pulse and dir_i high means forward
`timescale 1ns/1ps
`default_nettype none
module pms_load_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic wall_en_i,
  input wire logic lose_i,
  input wire logic signed [31:0] wall_pos_i,
  input wire logic [7:0] heavy_i,
  output logic [7:0] load_o,
  output logic signed [31:0] pos_o,
  output logic [15:0] back_cnt_o
);
  // shaft position and backward step count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o <= 32'h0;
      back_cnt_o <= 16'h0;
    end else if (step_i) begin
      pos_o <= dir_i ? pos_o + 32'sh1 : pos_o - 32'sh1;
      back_cnt_o <= dir_i ? back_cnt_o : back_cnt_o + 16'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_o <= 8'h00;
    end else begin
      load_o <= (wall_en_i && !lose_i && pos_o >= wall_pos_i) ? heavy_i : 8'h05;
    end
  end
endmodule : pms_load_model
`default_nettype wire

// ---- pms_core_tb.sv ----
// testbench for the push motion sequencer with a mechanical load model
// assumes the checker is bound to the core by its own file
`timescale 1ns/1ps
`default_nettype none
module pms_core_tb
  import pms_pkg::*;
();
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pms_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tstart = 1'b0, wall_en = 1'b0, lose = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, dmy;
  logic [2:0] tidx = 3'h0;
  logic signed [31:0] wall_pos = 32'h0, mpos;
  logic [31:0] rdat;
  logic ack, step, dir, inpos, endo, sup;
  logic [7:0] torque, load;
  logic [15:0] back_cnt;
  int num_errors = 0, tests_run = 0, cyc_cnt = 0;
  pms_cfg_t cfg;
  pms_row_t rows [0:10] = '{'{1'b0, 8'h08, 32'h0, 32'h1}, '{1'b0, 8'h1C, 32'h0, 32'h14},
    '{1'b0, 8'h20, 32'h0, 32'h1}, '{1'b0, 8'h18, 32'h0, 32'h1}, '{1'b1, 8'h08, 32'h88B8, 32'h88B8},
    '{1'b1, 8'h0C, 32'h7A120, 32'h7A120}, '{1'b1, 8'h14, 32'h270F, 32'h270F},
    '{1'b1, 8'h10, 32'hF800_0001, 32'hF800_0001}, '{1'b1, 8'h28, 32'h2710, 32'h2710},
    '{1'b1, 8'h2C, 32'h5, 32'h0}, '{1'b1, 8'h3C, 32'h5, 32'h0}};
  pms_row_t bad [0:7] = '{'{1'b1, 8'h1C, 32'h13, 32'h0}, '{1'b1, 8'h1C, 32'h51, 32'h0},
    '{1'b1, 8'h20, 32'h101D1, 32'h0}, '{1'b1, 8'h28, 32'h2711, 32'h0}, '{1'b1, 8'h08, 32'h88B9, 32'h0},
    '{1'b1, 8'h0C, 32'h7A121, 32'h0}, '{1'b1, 8'h14, 32'h2710, 32'h0}, '{1'b1, 8'h10, 32'h0800_0000, 32'h0}};
  // clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  pms_core i_pms_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .table_move_start_input_i(tstart), .table_index_i(tidx), .load_i(load), .step_o(step), .dir_o(dir),
    .torque_limit_o(torque), .inposition_o(inpos), .end_o(endo), .alarm_suppress_o(sup));
  pms_load_model i_pms_load_model (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .dir_i(dir),
    .wall_en_i(wall_en), .lose_i(lose), .wall_pos_i(wall_pos), .heavy_i(8'h3C), .load_o(load),
    .pos_o(mpos), .back_cnt_o(back_cnt));
  // ****************
  // tasks
  // ****************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, dmy);
  endtask : wr
  task automatic set_cfg(input logic [7:0] base, input pms_cfg_t c);
    for (int i = 0; i < 9; i++) wr(base + 8'(4 * i), c[32 * (8 - i) +: 32]);
  endtask : set_cfg
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    wall_en <= 1'b0;
    lose <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg = '{32'h88B8, 32'h88B8, 32'h2, 32'h1, 32'h1, 32'h32, 32'h88B8, 32'h4, 32'h0};
  endtask : do_reset
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // watchdog on the whole run
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 95000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    do_reset();
    @(posedge clk_i);
    chk_val({24'h0, torque}, 32'h64);
    chk_bit(endo | inpos | sup | step, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      wb_xfer(1'b0, rows[i].a, 32'h0, q);
      chk_val(q, rows[i].e);
    end
    $display("register rows done");
    foreach (bad[i]) begin
      do_reset();
      set_cfg(8'h08, cfg);
      wr(bad[i].a, bad[i].d);
      wr(ADDR_CTRL, 32'h1);
      repeat (4) @(posedge clk_i);
      wb_xfer(1'b0, ADDR_STATUS, 32'h0, q);
      chk_bit(q[ST_REJECT_BIT], 1'b1);
      chk_bit(q[ST_BUSY_BIT], 1'b0);
    end
    $display("refused settings done");
    do_reset();
    wall_pos <= 32'h3;
    wall_en <= 1'b1;
    set_cfg(8'h08, cfg);
    wr(ADDR_CTRL, 32'h1);
    wait (sup === 1'b1);
    @(posedge clk_i);
    chk_val({24'h0, torque}, 32'h32);
    chk_bit(sup, 1'b1);
    wait (endo === 1'b1);
    repeat (2) @(posedge clk_i);
    chk_bit(inpos, 1'b1);
    q = mpos;
    repeat (3000) @(posedge clk_i);
    chk_val(mpos, q);
    chk_val({24'h0, torque}, 32'h32);
    chk_bit(sup, 1'b0);
    wb_xfer(1'b0, ADDR_POSITION, 32'h0, q);
    chk_val(q, mpos);
    wr(ADDR_CTRL, 32'h2);
    repeat (4) @(posedge clk_i);
    chk_val({24'h0, torque}, 32'h64);
    $display("stop mode push done");
    do_reset();
    wall_pos <= 32'h3;
    wall_en <= 1'b1;
    cfg.push_target = 32'h6;
    cfg.push_mode = 32'h2;
    set_cfg(8'hAC, cfg);
    tidx <= 3'h3;
    tstart <= 1'b1;
    repeat (2) @(posedge clk_i);
    tstart <= 1'b0;
    wait (endo === 1'b1);
    repeat (2) @(posedge clk_i);
    chk_bit(inpos, 1'b1);
    lose <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk_bit(inpos, 1'b0);
    chk_bit(endo, 1'b1);
    wr(ADDR_CTRL, 32'h2);
    repeat (4) @(posedge clk_i);
    do wb_xfer(1'b0, ADDR_STATUS, 32'h0, q); while (q[ST_BUSY_BIT] !== 1'b0);
    chk_val({16'h0, back_cnt}, 32'h2);
    $display("non-stop push done");
    do_reset();
    set_cfg(8'h08, cfg);
    wr(ADDR_CTRL, 32'h1);
    wait (mpos === 32'sh4);
    repeat (3000) @(posedge clk_i);
    chk_val(mpos, 32'h4);
    chk_bit(inpos | endo, 1'b0);
    wr(ADDR_CTRL, 32'h2);
    repeat (4) @(posedge clk_i);
    chk_bit(inpos & endo, 1'b1);
    $display("undetected push done");
    wrap_up();
  end
endmodule : pms_core_tb
`default_nettype wire
